/* File: bench/safety_cmd_model.sv */
`timescale 1ns/10ps
module safety_cmd_model #(
   parameter int unsigned PULSE_MAX = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // commanded levels and test pulse request
   input wire logic lvl_a,
   input wire logic lvl_b,
   input wire logic go,
   input wire logic [1:0] sel,
   input wire logic [3:0] len,
   // safety outputs towards the drive
   output logic safe_torque_in_a,
   output logic safe_torque_in_b
);
   logic [3:0] cnt_ff;
   logic [1:0] sel_ff;
   logic pulse;

   // self-test pulses are clipped so they never reach the drive's filter length
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= 4'h0;
         sel_ff <= 2'h0;
      end else if (go) begin
         cnt_ff <= (len > PULSE_MAX) ? 4'(PULSE_MAX) : len;
         sel_ff <= sel;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
   assign pulse = (cnt_ff != 4'h0);
   assign safe_torque_in_a = lvl_a & ~(pulse & sel_ff[0]);
   assign safe_torque_in_b = lvl_b & ~(pulse & sel_ff[1]);
endmodule

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
   import torque_cutoff_pkg::*;
   localparam int unsigned LOW = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic lvl_a = 1'b0;
   logic lvl_b = 1'b0;
   logic go = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [3:0] len = 4'h0;
   logic in_a;
   logic in_b;
   logic [3:0] diag = 4'h0;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 32'h0;
   logic [DATA_W-1:0] rd_val;
   logic [DATA_W-1:0] reg_rdata;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic gate_supply_en, phase_drive_en, status_lamp, fault_lamp, irq;
   logic [DATA_W-1:0] outs;
   logic [15:0] lfsr = 16'hA722;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;

   assign outs = 32'({gate_supply_en, phase_drive_en, status_lamp, fault_lamp, irq});

   safe_torque_off_logic #(.LOW_CYCLES(LOW), .DISC_CYCLES(32)) i_safe_torque_off_logic (
      .clk(clk), .rst(rst),
      .safe_torque_in_a(in_a), .safe_torque_in_b(in_b),
      .diag_anomaly(diag[0]), .supply_undervolt(diag[1]),
      .supply_overvolt(diag[2]), .out_stage_fail(diag[3]),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .gate_supply_en(gate_supply_en),
      .phase_drive_en(phase_drive_en), .status_lamp(status_lamp),
      .fault_lamp(fault_lamp), .irq(irq));

   safety_cmd_model #(.PULSE_MAX(LOW - 2)) i_safety_cmd_model (
      .clk(clk), .rst(rst), .lvl_a(lvl_a), .lvl_b(lvl_b), .go(go), .sel(sel),
      .len(len), .safe_torque_in_a(in_a), .safe_torque_in_b(in_b));

   always #5 clk = ~clk;

   function automatic logic [DATA_W-1:0] o(input logic g, input logic s, input logic f,
                                           input logic i);
      return 32'({g, g, s, f, i});
   endfunction

   // state word with both inputs high
   function automatic logic [DATA_W-1:0] sw(input logic en, input logic cut);
      logic [DATA_W-1:0] v;
      v = 32'h0;
      v[STW_IN_A] = 1'b1;
      v[STW_IN_B] = 1'b1;
      v[STW_ENABLED] = en;
      v[STW_TORQUE] = en;
      v[STW_CUTOFF] = cut;
      return v;
   endfunction

   function automatic logic [DATA_W-1:0] fb(input int k);
      return 32'h1 << k;
   endfunction

   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic end_sim();
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_errors++;
         end_sim();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      chk(outs, o(0, 0, 0, 0));
      wr(8'h10, 32'hFFFF_FFFF);
      rd(OFF_MASK);
      chk(rd_val, 32'h0);
      rd(OFF_CTRL);
      chk(rd_val, 32'h0);
      // enable attempt with both inputs low
      wr(OFF_CTRL, 32'h1);
      rd(OFF_FAULT);
      chk(rd_val, fb(FLT_LOW_EN));
      @(posedge clk);
      lvl_a <= 1'b1;
      lvl_b <= 1'b1;
      cyc(8);
      chk(outs, o(0, 0, 1, 0));
      rd(OFF_STATE);
      chk(rd_val, sw(0, 0));
      wr(OFF_CTRL, 32'h1);
      chk(outs, o(0, 0, 1, 0));
      wr(OFF_FAULT, 32'h3F);
      rd(OFF_STATE);
      chk(rd_val, sw(0, 1));
      wr(OFF_CTRL, 32'h1);
      chk(outs, o(1, 1, 0, 0));
      rd(OFF_FAULT);
      chk(rd_val, 32'h0);
      rd(OFF_STATE);
      chk(rd_val, sw(1, 1));
      // self-test pulses, random channel and length
      for (int k = 0; k < 12; k++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge clk);
         go <= 1'b1;
         sel <= (lfsr[1:0] == 2'h0) ? 2'h3 : lfsr[1:0];
         len <= (k == 0) ? 4'hF : lfsr[5:2];
         @(posedge clk);
         go <= 1'b0;
         cyc(14);
         chk(outs, o(1, 1, 0, 0));
      end
      // one channel drops and stays apart from the other
      @(posedge clk);
      lvl_a <= 1'b0;
      cyc(50);
      chk(outs, o(0, 0, 1, 0));
      rd(OFF_FAULT);
      chk(rd_val, fb(FLT_DROP) | fb(FLT_DISC));
      @(posedge clk);
      lvl_a <= 1'b1;
      cyc(10);
      chk(outs, o(0, 0, 1, 0));
      wr(OFF_MASK, fb(FLT_DROP));
      chk(irq, 1'b1);
      wr(OFF_MASK, 32'h0);
      chk(irq, 1'b0);
      wr(OFF_MASK, 32'h3F);
      wr(OFF_FAULT, 32'h3F);
      chk(outs, o(0, 1, 0, 0));
      wr(OFF_CTRL, 32'h1);
      chk(outs, o(1, 1, 0, 0));
      // disable first, then cut both inputs
      wr(OFF_CTRL, 32'h2);
      @(posedge clk);
      lvl_a <= 1'b0;
      lvl_b <= 1'b0;
      cyc(15);
      rd(OFF_FAULT);
      chk(rd_val, 32'h0);
      @(posedge clk);
      lvl_a <= 1'b1;
      lvl_b <= 1'b1;
      cyc(6);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CTRL, 32'h1);
         @(posedge clk);
         diag <= 4'(1 << i);
         @(posedge clk);
         diag <= 4'h0;
         #1;
         chk(outs, o(0, 0, 1, 1));
         rd(OFF_FAULT);
         chk(rd_val, fb(i == 0 ? FLT_DIAG : (i == 3 ? FLT_OUTSTAGE : FLT_SUPPLY)));
         wr(OFF_FAULT, 32'h3F);
      end
      // enable, then a second reset in mid-run
      wr(OFF_CTRL, 32'h1);
      chk(outs, o(1, 1, 0, 0));
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      chk(outs, o(0, 0, 0, 0));
      rd(OFF_MASK);
      chk(rd_val, 32'h0);
      cyc(3);
      chk(outs, o(0, 1, 0, 0));
      end_sim();
   end
endmodule

/* File: src/safe_chan_if.sv */
`timescale 1ns/10ps
interface safe_chan_if;
   logic raw;
   logic lvl;
   logic fell;

   modport filt (
      input raw,
      output lvl,
      output fell
   );

   modport core (
      input lvl,
      input fell
   );
endinterface

/* File: src/safe_input_filter.sv */
`timescale 1ns/10ps
module safe_input_filter #(
   parameter int unsigned LOW_CYCLES = torque_cutoff_pkg::LOW_FILT_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // channel
   safe_chan_if.filt ch
);
   import torque_cutoff_pkg::*;

   localparam int CNT_W = $clog2(LOW_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOW_CYCLES - 1);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic lvl;
      logic fell;
      logic [CNT_W-1:0] cnt;
   } filt_s;

   filt_s s_ff;
   filt_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.sync1 = ch.raw;
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.fell = 1'b0;
      if (s_ff.sync2) begin
         nxt_s.lvl = 1'b1;
         nxt_s.cnt = '0;
      end else if (s_ff.lvl) begin
         // short self-test pulses die here before they reach the core
         if (s_ff.cnt == CNT_LAST) begin
            nxt_s.lvl = 1'b0;
            nxt_s.fell = 1'b1;
            nxt_s.cnt = '0;
         end else begin
            nxt_s.cnt = s_ff.cnt + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ch.lvl = s_ff.lvl;
   assign ch.fell = s_ff.fell;

   AST_LOW_PULSE_FILTERED: assert property (
      @(posedge clk) disable iff (rst)
      $fell(s_ff.lvl) && !$past(rst) |-> $past(s_ff.cnt) == CNT_LAST && !$past(s_ff.sync2))
      else $error("filtered level dropped before the low time elapsed");

   AST_SYNC_RISE: assert property (
      @(posedge clk) disable iff (rst)
      ch.raw ##1 ch.raw |=> ##1 s_ff.lvl)
      else $error("high input not passed after two sync stages");

endmodule

/* File: src/safe_torque_off_logic.sv */
`timescale 1ns/10ps
// Behaviour
// - torque only when enabled, faultless, both inputs high
// - any input falling removes torque, enters safe
// - low pulses shorter than 1 ms ignored
// - safe state: driver unpowered, no automatic restart
// - re-enable: inputs high, alarms cleared, enable command
// - cutoff logic state readable as status bit 24
// - lamp lit only with inputs high, no fault
// - diagnostic anomaly forces safe state, warns software, lamp
// - supply or output stage fault removes torque, lamp
// - single channel fault forces torque-removed safe state
// - disable before inputs drop raises no alarm
// - enable with inputs low alarms, torque stays off
// - that alarm latches until software clears it
// - cleared, inputs high, enable restores torque cleanly
// - supervision always runs, cannot be switched off
module safe_torque_off_logic #(
   parameter int unsigned LOW_CYCLES = torque_cutoff_pkg::LOW_FILT_CYCLES,
   parameter int unsigned DISC_CYCLES = torque_cutoff_pkg::DISC_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // safety inputs, active high
   input wire logic safe_torque_in_a,
   input wire logic safe_torque_in_b,
   // diagnostics
   input wire logic diag_anomaly,
   input wire logic supply_undervolt,
   input wire logic supply_overvolt,
   input wire logic out_stage_fail,
   // register port
   input wire logic [torque_cutoff_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [torque_cutoff_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [torque_cutoff_pkg::DATA_W-1:0] reg_rdata,
   // power stage
   output logic gate_supply_en,
   output logic phase_drive_en,
   // indicators
   output logic status_lamp,
   output logic fault_lamp,
   output logic irq
);
   import torque_cutoff_pkg::*;

   localparam int DISC_W = $clog2(DISC_CYCLES + 1);
   localparam logic [DISC_W-1:0] DISC_LAST = DISC_W'(DISC_CYCLES - 1);

   typedef struct packed {
      drive_state_e st;
      fault_t flt;
      fault_t mask;
      logic [DISC_W-1:0] disc_cnt;
      logic lamp;
      logic flamp;
      logic irq;
      logic [DATA_W-1:0] rdata;
   } core_s;

   localparam core_s CORE_RST = '{
      st: DRV_SAFE,
      flt: FAULT_RST,
      mask: MASK_RST,
      disc_cnt: '0,
      lamp: 1'b0,
      flamp: 1'b0,
      irq: 1'b0,
      rdata: '0
   };

   function automatic logic hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] off,
      input logic stb
   );
      return stb && (addr == off);
   endfunction

   core_s s_ff;
   core_s nxt_s;

   safe_chan_if ch_a ();
   safe_chan_if ch_b ();

   logic a_lvl;
   logic b_lvl;
   logic both_hi;
   logic fell_any;
   logic enable_cmd;
   logic disable_cmd;
   logic in_safe;
   fault_t flt_set;
   fault_t flt_clr;

   // each channel owns a filter, so a dead stage in one shows as disagreement
   assign ch_a.raw = safe_torque_in_a;
   assign ch_b.raw = safe_torque_in_b;

   safe_input_filter #(
      .LOW_CYCLES(LOW_CYCLES)
   ) u_filt_a (
      .clk(clk),
      .rst(rst),
      .ch(ch_a.filt)
   );

   safe_input_filter #(
      .LOW_CYCLES(LOW_CYCLES)
   ) u_filt_b (
      .clk(clk),
      .rst(rst),
      .ch(ch_b.filt)
   );

   assign a_lvl = ch_a.lvl;
   assign b_lvl = ch_b.lvl;
   assign both_hi = a_lvl && b_lvl;
   assign fell_any = ch_a.fell || ch_b.fell;
   assign in_safe = (s_ff.st != DRV_ENABLED);

   // both command bits in one write: enable acts from safe, disable acts once enabled
   assign enable_cmd = hit(reg_addr, OFF_CTRL, reg_wr) && reg_wdata[CTRL_ENABLE];
   assign disable_cmd = hit(reg_addr, OFF_CTRL, reg_wr) && reg_wdata[CTRL_DISABLE];
   assign flt_clr = hit(reg_addr, OFF_FAULT, reg_wr) ? reg_wdata[FLT_W-1:0] : '0;

   // fault sources run every cycle; no register can mask them out of the state machine
   always_comb begin
      flt_set = '0;
      // a source that stays high sets its bit again, so a clear cannot hide a live fault
      flt_set[FLT_LOW_EN] = in_safe && enable_cmd && !both_hi;
      flt_set[FLT_DROP] = !in_safe && fell_any;
      flt_set[FLT_DIAG] = diag_anomaly;
      flt_set[FLT_SUPPLY] = supply_undervolt || supply_overvolt;
      flt_set[FLT_OUTSTAGE] = out_stage_fail;
      flt_set[FLT_DISC] = (a_lvl != b_lvl) && (s_ff.disc_cnt == DISC_LAST);
   end

   always_comb begin
      nxt_s = s_ff;
      // set wins over a clear in the same cycle
      nxt_s.flt = (s_ff.flt & ~flt_clr) | flt_set;
      if (hit(reg_addr, OFF_MASK, reg_wr)) begin
         nxt_s.mask = reg_wdata[FLT_W-1:0];
      end
      // channels disagreeing after filtering point at a broken channel
      // limitation: a channel stuck high goes unseen while the other stays high
      if (a_lvl != b_lvl) begin
         if (s_ff.disc_cnt != DISC_LAST) begin
            nxt_s.disc_cnt = s_ff.disc_cnt + DISC_W'(1);
         end
      end else begin
         nxt_s.disc_cnt = '0;
      end
      case (s_ff.st)
         DRV_SAFE: begin
            // only an explicit command leaves safe state
            if (enable_cmd && both_hi && s_ff.flt == '0 && flt_set == '0) begin
               nxt_s.st = DRV_ENABLED;
            end
         end
         DRV_ENABLED: begin
            if (disable_cmd || !both_hi || fell_any) begin
               nxt_s.st = DRV_SAFE;
            end else if (s_ff.flt != '0 || flt_set != '0) begin
               nxt_s.st = DRV_SAFE;
            end
         end
         default: begin
            nxt_s.st = DRV_SAFE;
         end
      endcase
      nxt_s.lamp = both_hi && nxt_s.flt == '0;
      nxt_s.flamp = nxt_s.flt != '0;
      nxt_s.irq = (nxt_s.flt & nxt_s.mask) != '0;
      // read data stand only in the cycle after the strobe
      // the state word shows filtered levels, so a short test pulse never appears
      nxt_s.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            OFF_STATE: begin
               nxt_s.rdata[STW_IN_A] = a_lvl;
               nxt_s.rdata[STW_IN_B] = b_lvl;
               nxt_s.rdata[STW_ENABLED] = !in_safe;
               nxt_s.rdata[STW_TORQUE] = gate_supply_en;
               nxt_s.rdata[STW_CUTOFF] = both_hi && s_ff.flt == '0;
            end
            OFF_FAULT: begin
               nxt_s.rdata[FLT_W-1:0] = s_ff.flt;
            end
            OFF_MASK: begin
               nxt_s.rdata[FLT_W-1:0] = s_ff.mask;
            end
            default: begin
               nxt_s.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= CORE_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // gate supply switch and phase drive both follow the state flop
   // the mask only shapes the interrupt; nothing bypasses the state flop
   assign gate_supply_en = (s_ff.st == DRV_ENABLED);
   assign phase_drive_en = (s_ff.st == DRV_ENABLED);
   assign status_lamp = s_ff.lamp;
   assign fault_lamp = s_ff.flamp;
   assign irq = s_ff.irq;
   assign reg_rdata = s_ff.rdata;

   // checks on the pins, the register port and the internal fault word and disagreement counter
   AST_TORQUE_RISE_CAUSE: assert property (
      @(posedge clk) disable iff (rst)
      $rose(gate_supply_en) |-> $past(enable_cmd && both_hi && s_ff.flt == '0))
      else $error("torque granted without enable, inputs high and no fault");

   AST_INPUT_LOW_NO_TORQUE: assert property (
      @(posedge clk) disable iff (rst)
      !both_hi |=> !gate_supply_en && !phase_drive_en)
      else $error("torque present one cycle after an input was low");

   AST_FALL_REMOVES: assert property (
      @(posedge clk) disable iff (rst)
      fell_any |=> !gate_supply_en)
      else $error("input fall did not remove torque");

   AST_NO_AUTO_RESTART: assert property (
      @(posedge clk) disable iff (rst)
      !gate_supply_en && !enable_cmd |=> !gate_supply_en && !phase_drive_en)
      else $error("torque returned without an enable command");

   AST_STATE_WORD_BIT: assert property (
      @(posedge clk) disable iff (rst)
      hit(reg_addr, OFF_STATE, reg_rd) |=>
         reg_rdata[STW_CUTOFF] == $past(both_hi && s_ff.flt == '0))
      else $error("state word bit 24 does not show cutoff logic state");

   AST_LAMP_DARK_INPUT: assert property (
      @(posedge clk) disable iff (rst)
      !both_hi |=> !status_lamp)
      else $error("lamp lit with an input low");

   AST_LAMP_DARK_FAULT: assert property (
      @(posedge clk) disable iff (rst)
      status_lamp |-> s_ff.flt == '0 && !fault_lamp)
      else $error("lamp lit while a fault is latched");

   AST_DIAG_SAFE: assert property (
      @(posedge clk) disable iff (rst)
      diag_anomaly |=> s_ff.flt[FLT_DIAG] && fault_lamp && !gate_supply_en)
      else $error("diagnostic anomaly did not force safe state and warn");

   AST_SUPPLY_SAFE: assert property (
      @(posedge clk) disable iff (rst)
      supply_undervolt || supply_overvolt || out_stage_fail |=>
         !gate_supply_en && fault_lamp)
      else $error("supply or output stage fault left torque on");

   AST_CHANNEL_DISAGREE: assert property (
      @(posedge clk) disable iff (rst)
      (a_lvl != b_lvl) && s_ff.disc_cnt == DISC_LAST |=>
         s_ff.flt[FLT_DISC] && !gate_supply_en)
      else $error("lasting channel disagreement not faulted");

   AST_DISABLED_DROP_QUIET: assert property (
      @(posedge clk) disable iff (rst)
      !gate_supply_en && fell_any && !enable_cmd && s_ff.flt == '0 |=>
         !s_ff.flt[FLT_DROP] && !s_ff.flt[FLT_LOW_EN])
      else $error("alarm raised for input drop while disabled");

   AST_ENABLE_LOW_ALARM: assert property (
      @(posedge clk) disable iff (rst)
      !gate_supply_en && enable_cmd && !both_hi |=>
         s_ff.flt[FLT_LOW_EN] && !gate_supply_en)
      else $error("enable with inputs low not alarmed");

   AST_ALARM_LATCHED: assert property (
      @(posedge clk) disable iff (rst)
      s_ff.flt[FLT_LOW_EN] && !flt_clr[FLT_LOW_EN] |=>
         s_ff.flt[FLT_LOW_EN] && !gate_supply_en)
      else $error("inputs-low alarm lost without software clear");

   AST_CLEAN_ENABLE: assert property (
      @(posedge clk) disable iff (rst)
      !gate_supply_en && enable_cmd && both_hi && s_ff.flt == '0 && flt_set == '0 |=>
         gate_supply_en && s_ff.flt == '0)
      else $error("clean enable did not restore torque");

   AST_STATE_WORD_ENABLED: assert property (
      @(posedge clk) disable iff (rst)
      hit(reg_addr, OFF_STATE, reg_rd) |=>
         reg_rdata[STW_ENABLED] == $past(gate_supply_en))
      else $error("state word enabled bit does not follow the drive state");

   AST_RDATA_ONE_CYCLE: assert property (
      @(posedge clk) disable iff (rst)
      !reg_rd |=> reg_rdata == '0)
      else $error("read data stood longer than one cycle");

   AST_LAMP_LIT_CAUSE: assert property (
      @(posedge clk) disable iff (rst)
      status_lamp |-> $past(both_hi))
      else $error("lamp lit although an input was low the cycle before");

   AST_FAULT_BLOCKS_ENABLE: assert property (
      @(posedge clk) disable iff (rst)
      !gate_supply_en && s_ff.flt != '0 |=> !gate_supply_en)
      else $error("torque granted while an alarm was still latched");

   AST_DISC_RESTART: assert property (
      @(posedge clk) disable iff (rst)
      a_lvl == b_lvl |=> s_ff.disc_cnt == '0)
      else $error("disagreement counter kept running after channels agreed");

   AST_DISABLE_QUIET: assert property (
      @(posedge clk) disable iff (rst)
      gate_supply_en && disable_cmd && s_ff.flt == '0 && flt_set == '0 |=>
         !gate_supply_en && s_ff.flt == '0)
      else $error("software disable raised an alarm or kept torque");

   AST_DROP_WHILE_ENABLED: assert property (
      @(posedge clk) disable iff (rst)
      gate_supply_en && fell_any |=> s_ff.flt[FLT_DROP] && fault_lamp)
      else $error("input fall while enabled not alarmed");

   AST_WARN_IRQ: assert property (
      @(posedge clk) disable iff (rst)
      diag_anomaly && s_ff.mask[FLT_DIAG] && !hit(reg_addr, OFF_MASK, reg_wr) |=> irq)
      else $error("unmasked diagnostic anomaly did not raise the interrupt");

   AST_ENABLE_IGNORED_ALARM: assert property (
      @(posedge clk) disable iff (rst)
      !gate_supply_en && enable_cmd && s_ff.flt[FLT_LOW_EN] |=>
         !gate_supply_en && s_ff.flt[FLT_LOW_EN])
      else $error("enable accepted while the inputs-low alarm was latched");

endmodule

/* File: src/torque_cutoff_pkg.sv */
package torque_cutoff_pkg;

   // timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned LOW_FILT_NS = 1_000_000;
   localparam int unsigned LOW_FILT_CYCLES = (LOW_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DISC_NS = 10_000_000;
   localparam int unsigned DISC_CYCLES = DISC_NS / CLK_PERIOD_NS;

   // register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_FAULT = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0C;

   // command register bits
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_DISABLE = 1;

   // logical_input_state_word bits
   localparam int STW_IN_A = 0;
   localparam int STW_IN_B = 1;
   localparam int STW_ENABLED = 2;
   localparam int STW_TORQUE = 3;
   localparam int STW_CUTOFF = 24;

   // primary_fault_word bits
   localparam int FLT_LOW_EN = 0;
   localparam int FLT_DROP = 1;
   localparam int FLT_DIAG = 2;
   localparam int FLT_SUPPLY = 3;
   localparam int FLT_OUTSTAGE = 4;
   localparam int FLT_DISC = 5;
   localparam int FLT_W = 6;

   typedef logic [FLT_W-1:0] fault_t;
   localparam fault_t FAULT_RST = 6'h00;
   localparam fault_t MASK_RST = 6'h00;

   typedef enum logic [1:0] {
      DRV_SAFE = 2'b01,
      DRV_ENABLED = 2'b10
   } drive_state_e;

endpackage
